// >>> core/ddcs_pkg.sv
// constants for the second downconverter decimation and source select block
//
// Behaviour
// - bit 3 of the control register selects real or complex output and so the total decimation.
// - with bit 3 clear both in-phase and quadrature samples carry data.
// - with bit 3 set only in-phase carries data, made real by an extra sample-rate mix.
// - rate code 000 uses half-band one and two, decimating by 2 real or 4 complex.
// - rate code 001 uses half-band one to three, decimating by 4 real or 8 complex.
// - rate code 010 uses all four half-bands, decimating by 8 real or 16 complex.
// - rate code 011 uses half-band one only, full rate real or by 2 complex.
// - rate code 100 uses half-band one and the third-band, by 3 real or 6 complex.
// - rate code 101 uses half-band one, two and the third-band, by 6 real or 12 complex.
// - rate code 110 uses half-band one to three and the third-band, by 12 real or 24 complex.
// - rate code 111 takes the chain from the extended field in bits 7:4 of the source register.
// - extended code 0 uses the third-band and all half-bands, by 24 real or 48 complex.
// - extended code 2 uses the fifth-band and half-band one, by 5 real or 10 complex.
// - extended code 3 uses the fifth-band and half-band one and two, by 10 real or 20 complex.
// - extended code 4 uses the fifth-band and half-band one to three, by 20 real or 40 complex.
package ddcs_pkg;
  localparam int SW = 16;
  localparam int AW = 12;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_MARGIN = 3;
  // register indices; byte address is four times the index
  localparam logic [AW-1:0] CTRL_IDX = 12'h350;
  localparam logic [AW-1:0] SRC_IDX = 12'h351;
  localparam logic [AW-1:0] STAT_IDX = 12'h352;
  localparam logic [AW-1:0] CTRL_ADDR = {CTRL_IDX[AW-3:0], 2'h0};
  localparam logic [AW-1:0] SRC_ADDR = {SRC_IDX[AW-3:0], 2'h0};
  localparam logic [AW-1:0] STAT_ADDR = {STAT_IDX[AW-3:0], 2'h0};
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SRC_RESET = 8'h00;
  localparam logic [7:0] SRC_WMASK = 8'hf5;
  localparam int C2R_BIT = 3;
  localparam int QSEL_BIT = 2;
  localparam int ISEL_BIT = 0;
  localparam int EXT_LSB = 4;
  localparam logic [2:0] RATE_EXT = 3'h7;
  localparam logic [3:0] EXT_MAX = 4'h4;
  localparam logic [3:0] EXT_RSVD = 4'h1;
  // stage mask: 0 hb one, 1 hb two, 2 hb three, 3 hb four, 4 third-band, 5 fifth-band
  // real-output factors indexed by primary rate code
  localparam logic [6:0][5:0] PRI_DEC = {6'h0c, 6'h06, 6'h03, 6'h01, 6'h08, 6'h04, 6'h02};
  localparam logic [6:0][5:0] PRI_MASK = {6'h17, 6'h13, 6'h11, 6'h01, 6'h0f, 6'h07, 6'h03};
  // real-output factors indexed by extended rate code, entry 1 reserved
  localparam logic [4:0][5:0] EXT_DEC = {6'h14, 6'h0a, 6'h05, 6'h00, 6'h18};
  localparam logic [4:0][5:0] EXT_MASK = {6'h27, 6'h23, 6'h21, 6'h00, 6'h1f};
  typedef enum logic [1:0] {MIX_P0, MIX_P1, MIX_P2, MIX_P3} ddcs_mix_t;
endpackage

// >>> core/ddcs_top.sv
// second downconverter source select, decimation select and output fifo
//
// The APB register port was chosen for this implementation.

// ==========================================
// fifo with registered head
module ddcs_fifo
  import ddcs_pkg::*;
#(
  parameter int W = 32,
  parameter int D = 32
)(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  input  wire logic               in_valid,
  output logic                    in_ready,
  input  wire logic [W-1:0]       in_data,
  output logic                    out_valid,
  input  wire logic               out_ready,
  output logic [W-1:0]            out_data,
  output logic [$clog2(D+1)-1:0]  level
);
  localparam int PW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  wire           push = ce && in_valid && in_ready;
  wire           pop = ce && (level != '0) && (!out_valid || out_ready);
  assign in_ready = (level < D[$clog2(D+1)-1:0]);

  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr <= '0;
      rptr <= '0;
      level <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (ce)
    begin
      if (push)
      begin
        wptr <= wptr + 1'b1;
      end
      if (pop)
      begin
        rptr <= rptr + 1'b1;
        out_data <= mem[rptr];
        out_valid <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid <= 1'b0;
      end
      level <= level + {{($clog2(D+1)-1){1'b0}}, push} - {{($clog2(D+1)-1){1'b0}}, pop};
    end
  end
endmodule

// ==========================================
// top
module ddcs_top
  import ddcs_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           ce,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [AW-1:0]  paddr,
  input  wire logic [31:0]    pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic [SW-1:0]  chan_a,
  input  wire logic [SW-1:0]  chan_b,
  input  wire logic           samp_valid,
  output logic                samp_ready,
  output logic                out_valid,
  input  wire logic           out_ready,
  output logic [SW-1:0]       out_i,
  output logic [SW-1:0]       out_q,
  output logic                out_real
);
  localparam int LW = $clog2(FIFO_DEPTH+1);

  // ==========================================
  // chain decode
  function automatic logic [12:0] chain_decode(input logic [2:0] rate, input logic [3:0] ext);
    logic [12:0] r;
    r = '0;
    if (rate != RATE_EXT)
    begin
      r = {1'b1, PRI_DEC[rate], PRI_MASK[rate]};
    end
    else if (ext <= EXT_MAX && ext != EXT_RSVD)
    begin
      r = {1'b1, EXT_DEC[ext[2:0]], EXT_MASK[ext[2:0]]};
    end
    return r;
  endfunction

  logic [7:0]  ctrl;
  logic [7:0]  src;
  logic [5:0]  act_factor;
  logic [5:0]  act_mask;
  logic        act_c2r;
  logic [5:0]  cnt;
  ddcs_mix_t   mix;
  logic        push_valid;
  logic [SW-1:0] push_i;
  logic [SW-1:0] push_q;
  logic        fifo_in_ready;
  logic [LW-1:0] fifo_level;

  // ==========================================
  // apb decode
  wire        acc_phase = psel && penable;
  wire        hit_ctrl = (paddr == CTRL_ADDR);
  wire        hit_src = (paddr == SRC_ADDR);
  wire        hit_stat = (paddr == STAT_ADDR);
  wire        mapped = hit_ctrl || hit_src || hit_stat;
  wire        wr_now = acc_phase && pready && pwrite;
  wire [7:0]  stat_val = {act_c2r, 1'b0, act_mask};
  wire [31:0] rd_val = hit_ctrl ? {24'h0, ctrl} :
                       hit_src ? {24'h0, src & SRC_WMASK} :
                       hit_stat ? {18'h0, act_factor, stat_val} : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      ctrl <= CTRL_RESET;
      src <= SRC_RESET;
    end
    else if (ce)
    begin
      pready <= acc_phase && !pready;
      if (acc_phase && !pready)
      begin
        prdata <= pwrite ? 32'h0 : rd_val;
        pslverr <= !mapped || (pwrite && hit_stat);
      end
      if (wr_now && hit_ctrl)
      begin
        ctrl <= pwdata[7:0];
      end
      if (wr_now && hit_src)
      begin
        src <= pwdata[7:0] & SRC_WMASK;
      end
    end
  end

  // ==========================================
  // active chain, reserved codes keep the previous one
  wire [12:0] dec = chain_decode(ctrl[2:0], src[7:EXT_LSB]);
  wire [5:0]  tot_factor = act_c2r ? act_factor : {act_factor[4:0], 1'b0};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_factor <= PRI_DEC[0];
      act_mask <= PRI_MASK[0];
      act_c2r <= 1'b0;
    end
    else if (ce && dec[12])
    begin
      act_factor <= dec[11:6];
      act_mask <= dec[5:0];
      act_c2r <= ctrl[C2R_BIT];
    end
  end

  // ==========================================
  // source select, decimation and real conversion
  wire [SW-1:0] i_in = src[ISEL_BIT] ? chan_b : chan_a;
  wire [SW-1:0] q_in = src[QSEL_BIT] ? chan_b : chan_a;
  wire          accept = ce && samp_valid && samp_ready;
  wire          emit = accept && (cnt >= tot_factor - 6'h01);
  wire [SW-1:0] neg_i = SW'(-i_in);
  wire [SW-1:0] neg_q = SW'(-q_in);
  wire [SW-1:0] real_v = (mix == MIX_P0) ? i_in :
                         (mix == MIX_P1) ? neg_q :
                         (mix == MIX_P2) ? neg_i : q_in;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= '0;
      mix <= MIX_P0;
      push_valid <= 1'b0;
      push_i <= '0;
      push_q <= '0;
      samp_ready <= 1'b0;
      out_real <= 1'b0;
    end
    else if (ce)
    begin
      samp_ready <= fifo_level < LW'(FIFO_DEPTH - FIFO_MARGIN);
      out_real <= act_c2r;
      push_valid <= emit;
      if (accept)
      begin
        cnt <= emit ? '0 : cnt + 6'h01;
      end
      if (emit)
      begin
        push_i <= act_c2r ? real_v : i_in;
        push_q <= act_c2r ? '0 : q_in;
        mix <= ddcs_mix_t'(mix + 2'h1);
      end
    end
  end

  ddcs_fifo #(
    .W (2*SW),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({push_i, push_q}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  ({out_i, out_q}),
    .level     (fifo_level)
  );

  // ==========================================
  // assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_ctrl_write;
    ce && wr_now && hit_ctrl;
  endsequence

  property p_c2r_store;
    s_ctrl_write ##1 ce[*1] |-> ctrl[C2R_BIT] == $past(pwdata[C2R_BIT]);
  endproperty
  a_c2r_store: assert property (p_c2r_store) else $error("control bit not stored");

  property p_complex_q;
    (emit && !act_c2r) |=> push_valid && push_q == $past(q_in);
  endproperty
  a_complex_q: assert property (p_complex_q) else $error("quadrature sample lost");

  property p_real_q;
    (emit && act_c2r) |=> push_valid && push_q == '0;
  endproperty
  a_real_q: assert property (p_real_q) else $error("quadrature not zero in real");

  property p_rate0_real;
    (ce && ctrl[2:0] == 3'h0 && ctrl[C2R_BIT]) |=> act_factor == 6'h02 && act_c2r;
  endproperty
  a_rate0_real: assert property (p_rate0_real) else $error("rate 0 real factor wrong");

  property p_rate2_cplx;
    (ce && ctrl[2:0] == 3'h2 && !ctrl[C2R_BIT]) |=> tot_factor == 6'h10;
  endproperty
  a_rate2_cplx: assert property (p_rate2_cplx) else $error("rate 2 complex factor wrong");

  property p_ext2;
    (ce && ctrl[2:0] == RATE_EXT && src[7:4] == 4'h2) |=> act_mask == 6'h21;
  endproperty
  a_ext2: assert property (p_ext2) else $error("extended code 2 chain wrong");

  property p_rsvd_hold;
    (ce && ctrl[2:0] == RATE_EXT && src[7:4] > EXT_MAX) |=> $stable(act_factor) && $stable(act_mask);
  endproperty
  a_rsvd_hold: assert property (p_rsvd_hold) else $error("reserved code changed chain");

  property p_isel_b;
    (emit && !act_c2r && src[ISEL_BIT]) |=> push_i == $past(chan_b);
  endproperty
  a_isel_b: assert property (p_isel_b) else $error("in-phase source not channel b");

  property p_full_rate;
    (accept && act_c2r && act_factor == 6'h01) |-> emit;
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("full rate sample not emitted");
endmodule

// >>> tb/ddcs_adc_model.sv
// converter channel A and B sample source
module ddcs_adc_model
  import ddcs_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           ce,
  input  wire logic           gap,
  input  wire logic [15:0]    limit,
  input  wire logic           samp_ready,
  output logic                samp_valid,
  output logic [SW-1:0]       chan_a,
  output logic [SW-1:0]       chan_b,
  output logic [15:0]         taken
);
  logic        tick;
  wire  logic  take = ce && samp_valid && samp_ready;
  wire  logic [15:0] next_taken = taken + {15'h0, take};
  // lines not carrying a sample show its inverse
  assign chan_a = samp_valid ? {4'ha, taken[11:0]} : ~{4'ha, taken[11:0]};
  assign chan_b = samp_valid ? {4'hb, taken[11:0]} : ~{4'hb, taken[11:0]};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      taken      <= 16'h0;
      tick       <= 1'b0;
      samp_valid <= 1'b0;
    end
    else
    begin
      tick       <= ~tick;
      taken      <= next_taken;
      samp_valid <= (next_taken < limit) && ((samp_valid && !take) || !gap || tick);
    end
  end
endmodule

// >>> tb/tb.sv
// self-checking bench for the decimation and source select block
module tb
  import ddcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic              out_ready = 1, gap = 0, mode_real = 0;
  logic              pready, pslverr, samp_valid, samp_ready, out_valid, out_real;
  logic [AW-1:0]     paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd;
  logic [SW-1:0]     chan_a, chan_b, out_i, out_q;
  logic [15:0]       limit = '0, taken;
  int                fails = 0, compares = 0, n_out = 0, n_all = 0;
  logic [15:0]       ri;
  always #50 pclk = ~pclk;
  ddcs_top ddcs_top_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .chan_a, .chan_b, .samp_valid, .samp_ready, .out_valid,
    .out_ready, .out_i, .out_q, .out_real);
  ddcs_adc_model ddcs_adc_model_i (.pclk, .presetn, .ce, .gap, .limit, .samp_ready,
    .samp_valid, .chan_a, .chan_b, .taken);
  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++)
      @(posedge pclk);
    rd = pslverr ? 32'hffffffff : prdata;
    if (k == 20)
    begin
      fails++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic feed(input int n);
    int k;
    limit <= taken + n[15:0];
    @(posedge pclk);
    for (k = 0; k < 4000 && taken !== limit; k++)
      @(posedge pclk);
    if (k == 4000)
      close_out();
    repeat (10) @(posedge pclk);
  endtask
  function automatic logic [31:0] st(input logic [5:0] f, input logic r, input logic [5:0] m);
    return {18'h0, f, r, 1'b0, m};
  endfunction
  // ==========================================
  // output monitor
  always @(posedge pclk)
    if (out_valid === 1'b1 && out_ready === 1'b1)
    begin
      n_out++;
      if (mode_real)
      begin
        // phases i, -q, -i, q with i from channel b and q from channel a
        ri = (n_all[0] ^ n_all[1]) ? -out_i : out_i;
        chk({out_real, out_q, ri[15:12]}, {1'b1, 16'h0, (n_all[0] ? 4'ha : 4'hb)});
      end
      else
        chk({out_real, out_i[15:12], out_q[15:12], out_i[11:0] ^ out_q[11:0]}, 21'h0b_a000);
      n_all++;
    end
  // ==========================================
  // scenarios
  task automatic t_regs();
    apb(0, CTRL_ADDR, 0);
    chk(rd, 0);
    apb(0, STAT_ADDR, 0);
    chk(rd, st(2, 0, 6'h03));
    apb(1, SRC_ADDR, 32'hff);
    apb(0, SRC_ADDR, 0);
    chk(rd, 32'hf5);
    apb(0, 12'h000, 0);
    chk(rd, 32'hffffffff);
  endtask
  task automatic t_rates();
    logic [5:0] f[7] = '{2, 4, 8, 1, 3, 6, 12};
    logic [5:0] m[7] = '{6'h03, 6'h07, 6'h0f, 6'h01, 6'h11, 6'h13, 6'h17};
    for (int c = 0; c < 14; c++)
    begin
      apb(1, CTRL_ADDR, {28'h0, c[0], c[3:1]});
      apb(0, STAT_ADDR, 0);
      chk(rd, st(f[c/2], c[0], m[c/2]));
    end
  endtask
  task automatic t_ext();
    logic [3:0] e[4] = '{0, 2, 3, 4};
    logic [5:0] f[4] = '{24, 5, 10, 20};
    logic [5:0] m[4] = '{6'h1f, 6'h21, 6'h23, 6'h27};
    logic [7:0] bad[2] = '{8'h10, 8'hf0};
    for (int c = 0; c < 8; c++)
    begin
      apb(1, SRC_ADDR, {24'h0, e[c/2], 4'h0});
      apb(1, CTRL_ADDR, {28'h0, c[0], 3'h7});
      apb(0, STAT_ADDR, 0);
      chk(rd, st(f[c/2], c[0], m[c/2]));
    end
    for (int c = 0; c < 2; c++)
    begin
      apb(1, SRC_ADDR, {24'h0, bad[c]});
      apb(0, STAT_ADDR, 0);
      chk(rd, st(20, 1, 6'h27));
    end
  endtask
  task automatic t_stream();
    logic [7:0] s[5] = '{8'h01, 8'h01, 8'h01, 8'h21, 8'h21};
    logic [7:0] k[5] = '{8'h00, 8'h04, 8'h0b, 8'h07, 8'h0f};
    int         n[5] = '{4, 6, 1, 10, 5};
    for (int c = 0; c < 5; c++)
    begin
      apb(1, SRC_ADDR, {24'h0, s[c]});
      apb(1, CTRL_ADDR, {24'h0, k[c]});
      mode_real = k[c][3];
      gap <= c[0];
      feed(2 * n[c]);
      n_out = 0;
      feed(4 * n[c]);
      chk(n_out, 4);
    end
  endtask
  task automatic t_fill();
    logic [15:0] d;
    int          k;
    apb(1, SRC_ADDR, 32'h01);
    apb(1, CTRL_ADDR, 32'h0b);
    mode_real = 1;
    out_ready <= 1'b0;
    d = taken;
    limit <= taken + 16'd100;
    for (k = 0; k < 200 && samp_ready !== 1'b0; k++)
      @(posedge pclk);
    repeat (20) @(posedge pclk);
    chk(samp_ready, 0);
    limit <= taken;
    d = taken - d;
    chk(d >= 16'd29 && d <= 16'd34, 1);
    n_out = 0;
    out_ready <= 1'b1;
    repeat (60) @(posedge pclk);
    chk(n_out, d);
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rates();
    t_ext();
    t_stream();
    t_fill();
    close_out();
  end
endmodule
